// >>> dv/sad_cpu_model.sv
// processor-side bus model: phase-two clock, address, write data and control
`timescale 1ns/1ps

module sad_cpu_model #(
  parameter int HALF = 4
) (
  input  wire logic        clk,
  output logic      [15:0] cpu_addr,
  output logic      [7:0]  cpu_wdata,
  output logic             cpu_rw,
  output logic             cpu_sync,
  output logic             phi2
);
  int cnt;

  initial begin
    cnt = 0;
    phi2 = 1'b1;
    cpu_addr = 16'hFFFF;
    cpu_wdata = 8'h00;
    cpu_rw = 1'b1;
    cpu_sync = 1'b0;
  end

  // ----------------------------------------------------------------------
  // phase-two clock: runs free, one processor cycle is 2*HALF system clocks
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    cnt <= (cnt + 1) % (2 * HALF);
    phi2 <= ((cnt + 1) % (2 * HALF)) < HALF;
  end

  // ----------------------------------------------------------------------
  // one bus cycle: start drives at the rise of phi2 and returns at the last
  // high cycle, where the caller samples; finish holds until the last low cycle begins
  // ----------------------------------------------------------------------
  task automatic start(input logic [15:0] a, input logic rw, input logic [7:0] d, input logic sy);
    while (cnt != 2 * HALF - 1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cpu_addr <= a;
    cpu_rw <= rw;
    cpu_wdata <= d;
    cpu_sync <= sy;
    repeat (HALF - 1) @(posedge clk);
    #1;
  endtask

  task automatic finish();
    repeat (HALF) @(posedge clk);
    cpu_rw <= 1'b1;
    cpu_sync <= 1'b0;
    // released data lines must not keep showing the last byte
    cpu_wdata <= ~cpu_wdata;
    #1;
  endtask
endmodule

// >>> dv/system_address_decoder_tb.sv
// self-checking testbench of the system address decoder
`timescale 1ns/1ps
`include "sad_defines.svh"

module system_address_decoder_tb;
  localparam int DB = 8;
  localparam int H  = 4;

  typedef struct packed {
    logic [15:0] a;
    logic        rw;
    logic [7:0]  d;
    logic        oe;
    logic [8:0]  rd;
  } sad_row_s;

  logic                 clk         = 1'b0;
  logic                 rst_n       = 1'b0;
  logic                 decode_gate = 1'b1;
  logic                 reset_key   = 1'b0;
  logic                 stop_key    = 1'b0;
  logic                 step_mode   = 1'b0;
  logic [7:0]           port_a_in   = 8'hC3;
  logic [`SAD_PB_W-1:0] port_b_in   = 7'h2D;
  logic [15:0]          cpu_addr;
  logic [7:0]           cpu_wdata;
  logic                 cpu_rw;
  logic                 cpu_sync;
  logic                 phi2;
  logic [7:0]           cpu_rdata;
  logic                 cpu_rdata_oe;
  logic [7:0]           bs;
  logic                 kb_dev_sel;
  logic                 static_ram_we;
  logic [7:0]           port_a_out;
  logic [7:0]           port_a_oe;
  logic [`SAD_PB_W-1:0] port_b_out;
  logic [`SAD_PB_W-1:0] port_b_oe;
  logic                 cpu_reset_req;
  logic                 cpu_nmi_req;
  int                   n_mismatch  = 0;
  int                   tests_run   = 0;

  always #12.5 clk = ~clk;

  sad_cpu_model #(.HALF(H)) cpu (.clk(clk), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rw(cpu_rw),
    .cpu_sync(cpu_sync), .phi2(phi2));

  sad_decoder #(.DEBOUNCE_CYCLES(DB)) uut (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rw(cpu_rw), .cpu_sync(cpu_sync), .phi2(phi2), .decode_gate(decode_gate), .reset_key(reset_key),
    .stop_key(stop_key), .step_mode(step_mode), .port_a_in(port_a_in), .port_b_in(port_b_in),
    .cpu_rdata(cpu_rdata), .cpu_rdata_oe(cpu_rdata_oe), .block_sel_0(bs[0]), .block_sel_1(bs[1]),
    .block_sel_2(bs[2]), .block_sel_3(bs[3]), .block_sel_4(bs[4]), .block_sel_5(bs[5]), .block_sel_6(bs[6]),
    .block_sel_7(bs[7]), .kb_dev_sel(kb_dev_sel), .static_ram_we(static_ram_we), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_b_out(port_b_out), .port_b_oe(port_b_oe), .cpu_reset_req(cpu_reset_req),
    .cpu_nmi_req(cpu_nmi_req));

  // ----------------------------------------------------------------------
  // ordinary accesses: address, direction, data, expected enable and read byte
  // ----------------------------------------------------------------------
  sad_row_s rows [$] = '{
    '{16'h1701, 1'b0, 8'h5A, 1'b0, 9'h000}, '{16'h1701, 1'b1, 8'h00, 1'b1, 9'h15A},
    '{16'h1700, 1'b0, 8'hA5, 1'b0, 9'h000}, '{16'h1700, 1'b1, 8'h00, 1'b1, 9'h181},
    '{16'h1702, 1'b0, 8'hFF, 1'b0, 9'h000}, '{16'h1702, 1'b1, 8'h00, 1'b1, 9'h12D},
    '{16'h1703, 1'b0, 8'hFF, 1'b0, 9'h000}, '{16'h1703, 1'b1, 8'h00, 1'b1, 9'h17F},
    '{16'h1780, 1'b0, 8'h11, 1'b0, 9'h000}, '{16'h17BF, 1'b0, 8'h22, 1'b0, 9'h000},
    '{16'h1780, 1'b1, 8'h00, 1'b1, 9'h111}, '{16'h17BF, 1'b1, 8'h00, 1'b1, 9'h122},
    '{16'h1704, 1'b0, 8'h03, 1'b0, 9'h000}, '{16'h1704, 1'b1, 8'h00, 1'b1, 9'h103},
    '{16'h1705, 1'b1, 8'h00, 1'b1, 9'h100}, '{16'h170E, 1'b1, 8'h00, 1'b1, 9'h101},
    '{16'h170F, 1'b1, 8'h00, 1'b1, 9'h180}, '{16'h1704, 1'b1, 8'h00, 1'b1, 9'h100},
    '{16'h170C, 1'b0, 8'h05, 1'b0, 9'h000}, '{16'h170D, 1'b1, 8'h00, 1'b1, 9'h100},
    '{16'h16FF, 1'b1, 8'h00, 1'b0, 9'h000}, '{16'h17C0, 1'b1, 8'h00, 1'b0, 9'h000},
    '{16'h1740, 1'b1, 8'h00, 1'b0, 9'h000}, '{16'h0000, 1'b0, 8'h77, 1'b0, 9'h000},
    '{16'h03FF, 1'b1, 8'h00, 1'b0, 9'h000}, '{16'h0400, 1'b1, 8'h00, 1'b0, 9'h000},
    '{16'h0800, 1'b0, 8'h33, 1'b0, 9'h000}, '{16'h0C00, 1'b1, 8'h00, 1'b0, 9'h000},
    '{16'h1000, 1'b1, 8'h00, 1'b0, 9'h000}, '{16'h1400, 1'b1, 8'h00, 1'b0, 9'h000},
    '{16'h1800, 1'b1, 8'h00, 1'b0, 9'h000}, '{16'h1C00, 1'b1, 8'h00, 1'b0, 9'h000},
    '{16'h1FFF, 1'b1, 8'h00, 1'b0, 9'h000}, '{16'h2000, 1'b1, 8'h00, 1'b0, 9'h000},
    '{16'hFFFF, 1'b0, 8'h44, 1'b0, 9'h000}};

  function automatic logic [8:0] exp_sel(input logic [15:0] a, input logic g);
    logic [8:0] s;
    s = 9'h000;
    if (g && a < 16'h2000) begin
      s[a[12:10]] = 1'b1;
    end
    if (g && ((a >= `SAD_KB_IO_LO && a <= `SAD_KB_IO_HI) || (a >= `SAD_KB_RAM_LO && a <= `SAD_KB_RAM_HI))) begin
      s[8] = 1'b1;
    end
    return s;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic [15:0] a, input logic rw, input logic [7:0] d, input logic oe, input logic [8:0] rd);
    logic [8:0] es;
    cpu.start(a, rw, d, 1'b0);
    // gate is read only once the bus cycle runs, after any pending change of it has landed
    es = exp_sel(a, decode_gate);
    chk(16'({kb_dev_sel, bs}), 16'(es), "selects");
    chk(16'(static_ram_we), 16'(es[0] & ~rw), "ram write strobe");
    chk(16'(cpu_rdata_oe), 16'(oe), "data bus enable");
    if (rd[8]) begin
      chk(16'(cpu_rdata), 16'(rd[7:0]), "read data");
    end
    cpu.finish();
  endtask

  task automatic chk_zero();
    chk(16'({port_a_out, port_a_oe}), 16'h0000, "port a after reset");
    chk(16'({port_b_out, port_b_oe}), 16'h0000, "port b after reset");
    chk(16'({cpu_rdata, cpu_reset_req, cpu_nmi_req}), 16'h0000, "outputs after reset");
  endtask

  task automatic key(input int k, input logic v);
    @(posedge clk);
    if (k == 1) begin
      stop_key <= v;
    end else begin
      reset_key <= v;
    end
  endtask

  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_zero();
    foreach (rows[i]) begin
      acc(rows[i].a, rows[i].rw, rows[i].d, rows[i].oe, rows[i].rd);
    end
    chk(16'({port_a_out, port_a_oe}), 16'hA55A, "port a latch and direction");
    chk(16'({port_b_out, port_b_oe}), 16'h3FFF, "port b latch and direction");
    // gate low: nothing selected and the write is ignored
    decode_gate <= 1'b0;
    acc(16'h1701, 1'b0, 8'hFF, 1'b0, 9'h000);
    acc(16'h0010, 1'b0, 8'hFF, 1'b0, 9'h000);
    decode_gate <= 1'b1;
    acc(16'h1701, 1'b1, 8'h00, 1'b1, 9'h15A);
    // stepping: fetch outside the resident program raises the stop request
    step_mode <= 1'b1;
    cpu.start(16'h0200, 1'b1, 8'h00, 1'b1);
    chk(16'(cpu_nmi_req), 16'h0001, "step request on user fetch");
    cpu.finish();
    cpu.start(16'h1C00, 1'b1, 8'h00, 1'b1);
    chk(16'(cpu_nmi_req), 16'h0000, "no step request in resident program");
    cpu.finish();
    step_mode <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      key(k, 1'b1);
      repeat (DB - 2) @(posedge clk);
      key(k, 1'b0);
      repeat (DB + 3) @(posedge clk);
      #1;
      chk(16'(k == 1 ? cpu_nmi_req : cpu_reset_req), 16'h0000, "bounce ignored");
      key(k, 1'b1);
      repeat (DB - 2) @(posedge clk);
      #1;
      chk(16'(k == 1 ? cpu_nmi_req : cpu_reset_req), 16'h0000, "key not yet settled");
      repeat (4) @(posedge clk);
      #1;
      chk(16'(k == 1 ? cpu_nmi_req : cpu_reset_req), 16'h0001, "key settled pressed");
      key(k, 1'b0);
      repeat (DB + 3) @(posedge clk);
      #1;
      chk(16'(k == 1 ? cpu_nmi_req : cpu_reset_req), 16'h0000, "key settled released");
    end
    // reset in mid-run clears the port, read data and request registers
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_zero();
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    acc(16'h1701, 1'b1, 8'h00, 1'b1, 9'h100);
    results();
  end

  // the whole sequence needs well under a thousand clocks
  initial begin
    #(4000 * 25);
    n_mismatch++;
    results();
  end
endmodule

// >>> verilog/sad_decoder.sv
// system address decoder with application support device i/o, timer and ram
`timescale 1ns/1ps
`include "sad_defines.svh"

// Notes on behaviour
// - 8-bit data both ways
// - bus timing from phase-two clock; key debounce counts system clocks
// - lowest 8192 addresses form eight blocks
// - each block is four 256-location pages
// - block 7 and 6 enable ROMs
// - block 5 holds support device locations
// - blocks 1 to 4 left for expansion
// - block 0 selects static RAM
// - decoder makes all chip selects
// - 15 i/o pins with direction
// - i/o locations read and write normally
// - timer loads on write, reads state
// - 64 bytes scratch RAM per device
// - 1024-byte ROM per support device
// - debounce reset and stop keys
// - single instruction stepping mode
// - port registers at 1700 upward
// - device RAM at 1780 to 17BF
// - timer at 1704 to 170F
module sad_decoder #(
  parameter int unsigned DEBOUNCE_CYCLES = `SAD_DEBOUNCE_US * `SAD_CLK_KHZ / 1000
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [15:0]          cpu_addr,
  input  wire logic [7:0]           cpu_wdata,
  input  wire logic                 cpu_rw,
  input  wire logic                 cpu_sync,
  input  wire logic                 phi2,
  input  wire logic                 decode_gate,
  input  wire logic                 reset_key,
  input  wire logic                 stop_key,
  input  wire logic                 step_mode,
  input  wire logic [7:0]           port_a_in,
  input  wire logic [`SAD_PB_W-1:0] port_b_in,
  output logic      [7:0]           cpu_rdata,
  output logic                      cpu_rdata_oe,
  output logic                      block_sel_0,
  output logic                      block_sel_1,
  output logic                      block_sel_2,
  output logic                      block_sel_3,
  output logic                      block_sel_4,
  output logic                      block_sel_5,
  output logic                      block_sel_6,
  output logic                      block_sel_7,
  output logic                      kb_dev_sel,
  output logic                      static_ram_we,
  output logic      [7:0]           port_a_out,
  output logic      [7:0]           port_a_oe,
  output logic      [`SAD_PB_W-1:0] port_b_out,
  output logic      [`SAD_PB_W-1:0] port_b_oe,
  output logic                      cpu_reset_req,
  output logic                      cpu_nmi_req
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // block decode
  // ----------------------------------------------------------------------
  logic [`SAD_NUM_BLOCKS-1:0] block_sel_vec;

  // combinational decode of the address and decode_gate, so external parts see a select as soon as the address settles
  for (genvar g = 0; g < `SAD_NUM_BLOCKS; g++) begin : g_block
    assign block_sel_vec[g] = decode_gate && (cpu_addr[15:13] == `SAD_REGION_TOP)
                              && (cpu_addr[12:10] == 3'(g));
  end

  assign block_sel_0 = block_sel_vec[0];
  assign block_sel_1 = block_sel_vec[1];
  assign block_sel_2 = block_sel_vec[2];
  assign block_sel_3 = block_sel_vec[3];
  assign block_sel_4 = block_sel_vec[4];
  assign block_sel_5 = block_sel_vec[5];
  assign block_sel_6 = block_sel_vec[`SAD_BLK_APP_ROM];
  assign block_sel_7 = block_sel_vec[`SAD_BLK_KB_ROM];

  // static ram write strobe only in the second phase of a write cycle
  assign static_ram_we = block_sel_vec[`SAD_BLK_STATIC_RAM] && phi2 && !cpu_rw;

  assign kb_dev_sel = block_sel_vec[`SAD_BLK_SUPPORT]
                      && (((cpu_addr >= `SAD_KB_IO_LO) && (cpu_addr <= `SAD_KB_IO_HI))
                       || ((cpu_addr >= `SAD_KB_RAM_LO) && (cpu_addr <= `SAD_KB_RAM_HI)));

  sad_pkg::sad_target_e target;

  always_comb begin
    target = sad_pkg::sad_tgt_none;
    if (block_sel_vec[`SAD_BLK_SUPPORT]) begin
      if ((cpu_addr >= `SAD_APP_IO_LO) && (cpu_addr <= `SAD_APP_IO_HI)) begin
        target = sad_pkg::sad_tgt_io;
      end else if ((cpu_addr >= `SAD_APP_TMR_LO) && (cpu_addr <= `SAD_APP_TMR_HI)) begin
        target = sad_pkg::sad_tgt_timer;
      end else if ((cpu_addr >= `SAD_APP_RAM_LO) && (cpu_addr <= `SAD_APP_RAM_HI)) begin
        target = sad_pkg::sad_tgt_ram;
      end
    end
  end

  // ----------------------------------------------------------------------
  // phase-two timing
  // ----------------------------------------------------------------------
  logic phi2_q;
  logic sys_tick;
  logic wr_strobe;

  // the address and data are still valid on the falling phase-two edge
  assign sys_tick  = phi2_q && !phi2;
  assign wr_strobe = sys_tick && !cpu_rw;

  // ----------------------------------------------------------------------
  // scratch ram
  // ----------------------------------------------------------------------
  logic [7:0] ram_rdata;

  sad_ram u_ram (
    .clk   (clk),
    .we    (wr_strobe && (target == sad_pkg::sad_tgt_ram)),
    .addr  (cpu_addr[`SAD_RAM_AW-1:0]),
    .wdata (cpu_wdata),
    .rdata (ram_rdata)
  );

  // ----------------------------------------------------------------------
  // i/o ports, timer, read data and step trigger
  // ----------------------------------------------------------------------
  logic [7:0]           pa_value;
  logic [7:0]           pa_dir;
  logic [`SAD_PB_W-1:0] pb_value;
  logic [`SAD_PB_W-1:0] pb_dir;
  logic [7:0]           tmr_count;
  logic                 tmr_expired;
  logic                 nmi;
  logic                 next_phi2_q;
  logic [7:0]           next_pa_value;
  logic [7:0]           next_pa_dir;
  logic [`SAD_PB_W-1:0] next_pb_value;
  logic [`SAD_PB_W-1:0] next_pb_dir;
  logic [7:0]           next_tmr_count;
  logic                 next_tmr_expired;
  logic [7:0]           next_cpu_rdata;
  logic                 next_nmi;
  logic                 tmr_write;
  logic                 tmr_event;
  logic                 step_trigger;
  logic [1:0]           key_db;

  assign tmr_write    = wr_strobe && (target == sad_pkg::sad_tgt_timer);
  assign tmr_event    = sys_tick && (tmr_count == 8'h01);
  // stepping stops on every fetch outside the resident program blocks
  assign step_trigger = step_mode && cpu_sync && phi2 && !block_sel_vec[`SAD_BLK_SUPPORT]
                        && !block_sel_vec[`SAD_BLK_APP_ROM] && !block_sel_vec[`SAD_BLK_KB_ROM];

  always_comb begin
    next_phi2_q    = phi2;
    next_pa_value  = pa_value;
    next_pa_dir    = pa_dir;
    next_pb_value  = pb_value;
    next_pb_dir    = pb_dir;
    next_tmr_count = tmr_count;
    next_cpu_rdata = cpu_rdata;
    if (wr_strobe && (target == sad_pkg::sad_tgt_io)) begin
      case (cpu_addr[1:0])
        `SAD_IDX_PA_VALUE: next_pa_value = cpu_wdata;
        `SAD_IDX_PA_DIR:   next_pa_dir   = cpu_wdata;
        `SAD_IDX_PB_VALUE: next_pb_value = cpu_wdata[`SAD_PB_W-1:0];
        default:           next_pb_dir   = cpu_wdata[`SAD_PB_W-1:0];
      endcase
    end
    // a write always reloads; otherwise count one per falling phase-two edge until zero
    if (tmr_write) begin
      next_tmr_count = cpu_wdata;
    end else if (sys_tick && (tmr_count != `SAD_BYTE_ZERO)) begin
      next_tmr_count = tmr_count - 8'h01;
    end
    // the clear made by a reload wins over expiry set
    next_tmr_expired = (tmr_event && !tmr_write) || (tmr_expired && !tmr_write);
    if (phi2 && cpu_rw) begin
      case (target)
        sad_pkg::sad_tgt_io: begin
          case (cpu_addr[1:0])
            // input bits read the pin, output bits read the latch
            `SAD_IDX_PA_VALUE: next_cpu_rdata = (pa_value & pa_dir) | (port_a_in & ~pa_dir);
            `SAD_IDX_PA_DIR:   next_cpu_rdata = pa_dir;
            `SAD_IDX_PB_VALUE: next_cpu_rdata = {1'b0, (pb_value & pb_dir) | (port_b_in & ~pb_dir)};
            default:           next_cpu_rdata = {1'b0, pb_dir};
          endcase
        end
        sad_pkg::sad_tgt_timer: begin
          next_cpu_rdata = cpu_addr[`SAD_TMR_STATUS_BIT] ? {tmr_expired, 7'h00} : tmr_count;
        end
        sad_pkg::sad_tgt_ram: next_cpu_rdata = ram_rdata;
        default:              next_cpu_rdata = `SAD_BYTE_ZERO;
      endcase
    end
    next_nmi = key_db[1] || step_trigger;
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phi2_q      <= 1'b0;
      pa_value    <= `SAD_BYTE_ZERO;
      pa_dir      <= `SAD_BYTE_ZERO;
      pb_value    <= `SAD_PB_ZERO;
      pb_dir      <= `SAD_PB_ZERO;
      tmr_count   <= `SAD_BYTE_ZERO;
      tmr_expired <= 1'b0;
      cpu_rdata   <= `SAD_BYTE_ZERO;
      nmi         <= 1'b0;
    end else begin
      phi2_q      <= next_phi2_q;
      pa_value    <= next_pa_value;
      pa_dir      <= next_pa_dir;
      pb_value    <= next_pb_value;
      pb_dir      <= next_pb_dir;
      tmr_count   <= next_tmr_count;
      tmr_expired <= next_tmr_expired;
      cpu_rdata   <= next_cpu_rdata;
      nmi         <= next_nmi;
    end
  end

  assign port_a_out   = pa_value;
  assign port_a_oe    = pa_dir;
  assign port_b_out   = pb_value;
  assign port_b_oe    = pb_dir;
  assign cpu_nmi_req  = nmi;
  // drive only during the second phase of a read of an internal location
  assign cpu_rdata_oe = phi2 && cpu_rw && (target != sad_pkg::sad_tgt_none);

  // ----------------------------------------------------------------------
  // key debounce
  // ----------------------------------------------------------------------
  logic [1:0] key_raw;

  assign key_raw       = {stop_key, reset_key};
  assign cpu_reset_req = key_db[0];

  // a key changes state only after it has held the new level for the full time
  for (genvar k = 0; k < 2; k++) begin : g_key
    logic [`SAD_DB_CNT_W-1:0] cnt;
    logic [`SAD_DB_CNT_W-1:0] next_cnt;
    logic                     db;
    logic                     next_db;

    // one driver per key bit, so the vector is only ever assigned here
    assign key_db[k] = db;

    always_comb begin
      next_cnt = `SAD_DB_CNT_ZERO;
      next_db  = db;
      if (key_raw[k] != db) begin
        if (cnt == `SAD_DB_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
          next_db = key_raw[k];
        end else begin
          next_cnt = cnt + `SAD_DB_CNT_ONE;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        cnt <= `SAD_DB_CNT_ZERO;
        db  <= 1'b0;
      end else begin
        cnt <= next_cnt;
        db  <= next_db;
      end
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_sel_onehot;
    @(posedge clk) disable iff (!rst_sync_n) $onehot0(block_sel_vec);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("more than one block select");

  property p_gate_off;
    @(posedge clk) disable iff (!rst_sync_n) !decode_gate |-> (block_sel_vec == 8'h00) && !kb_dev_sel;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("select active with gate low");

  property p_block_map;
    @(posedge clk) disable iff (!rst_sync_n)
      (decode_gate && (cpu_addr[15:13] == 3'h0)) |-> block_sel_vec[cpu_addr[12:10]];
  endproperty
  a_block_map: assert property (p_block_map) else $error("wrong block for address");

  property p_outside;
    @(posedge clk) disable iff (!rst_sync_n) (cpu_addr[15:13] != 3'h0) |-> (block_sel_vec == 8'h00);
  endproperty
  a_outside: assert property (p_outside) else $error("select above decoded region");

  property p_ram_we;
    @(posedge clk) disable iff (!rst_sync_n) static_ram_we |-> (cpu_addr < 16'h0400) && !cpu_rw && phi2;
  endproperty
  a_ram_we: assert property (p_ram_we) else $error("ram write outside block 0");

  property p_dir_write;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr_strobe && decode_gate && (cpu_addr == 16'h1701)) |=> (port_a_oe == $past(cpu_wdata));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("port a direction not stored");

  property p_tmr_load;
    @(posedge clk) disable iff (!rst_sync_n)
      (wr_strobe && decode_gate && (cpu_addr == 16'h1704)) |=> (tmr_count == $past(cpu_wdata));
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("timer not loaded");

  property p_tmr_dec;
    @(posedge clk) disable iff (!rst_sync_n)
      (sys_tick && !tmr_write && (tmr_count != 8'h00)) |=> (tmr_count == $past(tmr_count) - 8'h01);
  endproperty
  a_tmr_dec: assert property (p_tmr_dec) else $error("timer did not count down");

  property p_tmr_hold;
    @(posedge clk) disable iff (!rst_sync_n) (!phi2_q && !tmr_write) |=> $stable(tmr_count);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer moved without a system clock");

  property p_step;
    @(posedge clk) disable iff (!rst_sync_n) step_trigger |=> cpu_nmi_req;
  endproperty
  a_step: assert property (p_step) else $error("step fetch raised no interrupt request");

  property p_kb_sel;
    @(posedge clk) disable iff (!rst_sync_n) kb_dev_sel |-> block_sel_5 && (target == sad_pkg::sad_tgt_none);
  endproperty
  a_kb_sel: assert property (p_kb_sel) else $error("keyboard device select overlaps");

  property p_key_stable;
    @(posedge clk) disable iff (!rst_sync_n) $rose(cpu_reset_req) |-> $past(reset_key, 2);
  endproperty
  a_key_stable: assert property (p_key_stable) else $error("reset request without held key");

  c_ram_write: cover property (@(posedge clk) disable iff (!rst_sync_n) static_ram_we);
  c_tmr_expire: cover property (@(posedge clk) disable iff (!rst_sync_n) $rose(tmr_expired));
  c_step: cover property (@(posedge clk) disable iff (!rst_sync_n) step_trigger);
  c_io_read: cover property (@(posedge clk) disable iff (!rst_sync_n) cpu_rdata_oe && (target == sad_pkg::sad_tgt_io));

endmodule

// >>> verilog/sad_defines.svh
// address map, timing and field constants of the system address decoder
`ifndef SAD_DEFINES_SVH
`define SAD_DEFINES_SVH

// ----------------------------------------------------------------------
// decoded region and blocks
// ----------------------------------------------------------------------
`define SAD_REGION_TOP     3'h0
`define SAD_NUM_BLOCKS     8
`define SAD_BLK_STATIC_RAM 0
`define SAD_BLK_SUPPORT    5
`define SAD_BLK_APP_ROM    6
`define SAD_BLK_KB_ROM     7

// ----------------------------------------------------------------------
// application support device locations
// ----------------------------------------------------------------------
`define SAD_APP_IO_LO      16'h1700
`define SAD_APP_IO_HI      16'h1703
`define SAD_APP_TMR_LO     16'h1704
`define SAD_APP_TMR_HI     16'h170F
`define SAD_APP_RAM_LO     16'h1780
`define SAD_APP_RAM_HI     16'h17BF
`define SAD_IDX_PA_VALUE   2'h0
`define SAD_IDX_PA_DIR     2'h1
`define SAD_IDX_PB_VALUE   2'h2
`define SAD_IDX_PB_DIR     2'h3
`define SAD_TMR_STATUS_BIT 0

// ----------------------------------------------------------------------
// keyboard/display support device locations inside block 5
// ----------------------------------------------------------------------
`define SAD_KB_IO_LO       16'h1740
`define SAD_KB_IO_HI       16'h177F
`define SAD_KB_RAM_LO      16'h17C0
`define SAD_KB_RAM_HI      16'h17FF

// ----------------------------------------------------------------------
// widths, reset values and timing
// ----------------------------------------------------------------------
`define SAD_PB_W           7
`define SAD_RAM_AW         6
`define SAD_BYTE_ZERO      8'h00
`define SAD_PB_ZERO        7'h00
`define SAD_CLK_KHZ        40000
`define SAD_DEBOUNCE_US    5000
`define SAD_DB_CNT_W       18
`define SAD_DB_CNT_ZERO    18'h00000
`define SAD_DB_CNT_ONE     18'h00001

`endif

// >>> verilog/sad_pkg.sv
// types shared by the system address decoder files
package sad_pkg;

  typedef enum logic [1:0] {
    sad_tgt_none,
    sad_tgt_io,
    sad_tgt_timer,
    sad_tgt_ram
  } sad_target_e;

endpackage

// >>> verilog/sad_ram.sv
// scratch memory of the application support device, registered read
`timescale 1ns/1ps
`include "sad_defines.svh"

module sad_ram (
  input  wire logic                    clk,
  input  wire logic                    we,
  input  wire logic [`SAD_RAM_AW-1:0]  addr,
  input  wire logic [7:0]              wdata,
  output logic      [7:0]              rdata
);

  logic [7:0] mem [0:(1<<`SAD_RAM_AW)-1];

  // no reset on the array: contents are undefined after power-up
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule
